// [common/accel_fifo_pkg.sv]
// Constants, types and register map of the accelerometer output path
package accel_fifo_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_TAP_THRESHOLD     = 8'h1D;
  localparam logic [7:0] OFS_TAP_MAX_DURATION  = 8'h21;
  localparam logic [7:0] OFS_TAP_LATENCY_TIME  = 8'h22;
  localparam logic [7:0] OFS_SECOND_TAP_WINDOW = 8'h23;
  localparam logic [7:0] OFS_TAP_AXIS_SELECT   = 8'h2A;
  localparam logic [7:0] OFS_MOTION_AXIS_STAT  = 8'h2B;
  localparam logic [7:0] OFS_EVENT_ENABLE      = 8'h2E;
  localparam logic [7:0] OFS_EVENT_MAP         = 8'h2F;
  localparam logic [7:0] OFS_EVENT_SOURCE      = 8'h30;
  localparam logic [7:0] OFS_OUTPUT_FORMAT     = 8'h31;
  localparam logic [7:0] OFS_X_AXIS_LOW_BYTE   = 8'h32;
  localparam logic [7:0] OFS_X_AXIS_HIGH_BYTE  = 8'h33;
  localparam logic [7:0] OFS_Y_AXIS_LOW_BYTE   = 8'h34;
  localparam logic [7:0] OFS_Y_AXIS_HIGH_BYTE  = 8'h35;
  localparam logic [7:0] OFS_Z_AXIS_LOW_BYTE   = 8'h36;
  localparam logic [7:0] OFS_Z_AXIS_HIGH_BYTE  = 8'h37;
  localparam logic [7:0] OFS_BUFFER_CONTROL    = 8'h38;
  localparam logic [7:0] OFS_BUFFER_STATUS     = 8'h39;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int   EV_DATA_READY  = 7;
  localparam int   EV_SINGLE_TAP  = 6;
  localparam int   EV_DOUBLE_TAP  = 5;
  localparam int   EV_WATERMARK   = 1;
  localparam int   EV_OVERRUN     = 0;
  localparam int   AXIS_SUPPRESS  = 3;
  localparam int   FMT_INVERT     = 5;
  localparam int   CTL_TRIG_SRC   = 5;
  localparam int   STAT_TRIG      = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int   BUF_DEPTH      = 32;
  localparam int   TAP_THR_SHIFT  = 4;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_BYPASS  = 2'b00,
    MODE_FIFO    = 2'b01,
    MODE_STREAM  = 2'b10,
    MODE_TRIGGER = 2'b11
  } buf_mode_t;

  typedef enum logic [2:0] {
    TAP_IDLE    = 3'b000,
    TAP_FIRST   = 3'b001,
    TAP_LATENCY = 3'b010,
    TAP_WINDOW  = 3'b011,
    TAP_SECOND  = 3'b100
  } tap_state_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } sample_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       burst_end;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [core/accel_output_fifo_tap_detect.sv]
// Output data registers, 32-level sample buffer and tap detection
// Contract
// - Six read-only bytes hold x, y, z data
// - Two's complement, low byte at lower address
// - Control top bits select buffer mode
// - Fifo mode stops storing at 32 samples
// - Stream mode keeps newest 32, drops oldest
// - Trigger mode keeps pre-trigger samples, then fills
// - Trigger source bit picks interrupt line one/two
// - Zero sample count sets watermark immediately
// - Sample count means watermark or pre-trigger depth
// - Status top bit shows trigger occurred
// - Status counts stored; each burst pops one
// - Up to 32 stored plus one output stage
// - Single tap fires when acceleration falls back
// - With double enabled, single waits for resolution
// - Latency then window; second tap starts inside
// - Suppress bit cancels on latency-time spike
// - Above at window start or long tap invalidates
// - Per-axis tap enables; single/double enabled separately
// - Double tap needs nonzero latency and window
// - Record first axis above threshold on tap
// - Tap status never cleared by reading
// - Data flags cleared by data read, others by source read
// - Map bit routes event to line one or two
// - Sleep stops buffering and data-ready; outside bypass, stored samples still move out and set data-ready
module accel_output_fifo_tap_detect #(
  parameter int DEPTH = accel_fifo_pkg::BUF_DEPTH
) (
  // Clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     resetn_i,
  // Sample path
  input  wire logic                     sample_valid_i,
  input  wire accel_fifo_pkg::sample_t  sample_i,
  input  wire logic                     sleep_i,
  // Register port
  input  wire accel_fifo_pkg::reg_req_t reg_req_i,
  output logic [7:0]                    reg_rdata_o,
  // Interrupt lines
  output logic                          interrupt_output_one_o,
  output logic                          interrupt_output_two_o
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic above_thr(input logic signed [15:0] v, input logic [7:0] thr);
    logic [16:0] mag;
    mag = v[15] ? 17'(-$signed({v[15], v})) : {1'b0, v};
    return mag > 17'({thr, {accel_fifo_pkg::TAP_THR_SHIFT{1'b0}}});
  endfunction

  function automatic logic in_data(input logic [7:0] a);
    return a >= accel_fifo_pkg::OFS_X_AXIS_LOW_BYTE && a <= accel_fifo_pkg::OFS_Z_AXIS_HIGH_BYTE;
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] tap_threshold_r, tap_max_duration_r, tap_latency_time_r, second_tap_window_r;
  logic [7:0] tap_axis_select_r, event_enable_r, event_map_r, output_format_control_r;
  logic [7:0] sample_buffer_control_r, motion_event_axis_status_r;
  logic       wr_ctl;

  assign wr_ctl = reg_req_i.wr && reg_req_i.addr == accel_fifo_pkg::OFS_BUFFER_CONTROL;

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tap_threshold_r         <= accel_fifo_pkg::REG_RESET;
      tap_max_duration_r      <= accel_fifo_pkg::REG_RESET;
      tap_latency_time_r      <= accel_fifo_pkg::REG_RESET;
      second_tap_window_r     <= accel_fifo_pkg::REG_RESET;
      tap_axis_select_r       <= accel_fifo_pkg::REG_RESET;
      event_enable_r          <= accel_fifo_pkg::REG_RESET;
      event_map_r             <= accel_fifo_pkg::REG_RESET;
      output_format_control_r <= accel_fifo_pkg::REG_RESET;
      sample_buffer_control_r <= accel_fifo_pkg::REG_RESET;
    end
    else if (reg_req_i.wr)
    begin
      unique case (reg_req_i.addr)
        accel_fifo_pkg::OFS_TAP_THRESHOLD:     tap_threshold_r         <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_TAP_MAX_DURATION:  tap_max_duration_r      <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_TAP_LATENCY_TIME:  tap_latency_time_r      <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_SECOND_TAP_WINDOW: second_tap_window_r     <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_TAP_AXIS_SELECT:   tap_axis_select_r       <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_EVENT_ENABLE:      event_enable_r          <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_EVENT_MAP:         event_map_r             <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_OUTPUT_FORMAT:     output_format_control_r <= reg_req_i.wdata;
        accel_fifo_pkg::OFS_BUFFER_CONTROL:    sample_buffer_control_r <= reg_req_i.wdata;
        default: ;
      endcase
    end
  end

  accel_fifo_pkg::buf_mode_t mode;
  logic [4:0]                samples_cfg;
  assign mode        = accel_fifo_pkg::buf_mode_t'(sample_buffer_control_r[7:6]);
  assign samples_cfg = sample_buffer_control_r[4:0];

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  accel_fifo_pkg::sample_t mem [DEPTH];
  accel_fifo_pkg::sample_t out_r;
  logic [PW-1:0] wr_ptr_r, rd_ptr_r;
  logic [CW-1:0] count_r;
  logic          out_valid_r, trig_r, data_read_r;
  logic          accept, full, push, move, discard, pop_out, lost;

  assign accept  = sample_valid_i && !sleep_i;
  assign full    = count_r == CW'(DEPTH);
  assign pop_out = reg_req_i.burst_end
                   && (data_read_r || (reg_req_i.rd && in_data(reg_req_i.addr)));
  assign move    = mode != accel_fifo_pkg::MODE_BYPASS && !out_valid_r && count_r != '0;

  always_comb
  begin
    push    = 1'b0;
    discard = 1'b0;
    lost    = 1'b0;
    unique case (mode)
      accel_fifo_pkg::MODE_BYPASS:
      begin
        lost = accept && out_valid_r && !pop_out;
      end
      accel_fifo_pkg::MODE_FIFO:
      begin
        push = accept && !full;
        lost = accept && full && out_valid_r;
      end
      accel_fifo_pkg::MODE_STREAM:
      begin
        push    = accept;
        discard = accept && full && !move;
        lost    = discard;
      end
      accel_fifo_pkg::MODE_TRIGGER:
      begin
        if (!trig_r)
        begin
          push    = accept;
          discard = accept && count_r != '0 && count_r >= CW'(samples_cfg) && !move;
        end
        else
        begin
          push = accept && !full;
          lost = accept && full && out_valid_r;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= sample_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else if (wr_ctl)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      wr_ptr_r <= push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= (move || discard) ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r  <= CW'(count_r + CW'(push) - CW'(move || discard));
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_r       <= '0;
      out_valid_r <= 1'b0;
    end
    else if (mode == accel_fifo_pkg::MODE_BYPASS && accept)
    begin
      out_r       <= sample_i;
      out_valid_r <= 1'b1;
    end
    else if (move)
    begin
      out_r       <= mem[rd_ptr_r];
      out_valid_r <= 1'b1;
    end
    else if (pop_out)
    begin
      out_valid_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      data_read_r <= 1'b0;
    end
    else if (reg_req_i.burst_end)
    begin
      data_read_r <= 1'b0;
    end
    else if (reg_req_i.rd && in_data(reg_req_i.addr))
    begin
      data_read_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Event flags and interrupt lines
  // ----------------------------------------
  logic       wm_r, ovr_r, single_r, double_r, wm_cond;
  logic       single_ev, double_ev, rd_src;
  logic [7:0] source, events;
  logic       line_one, line_two;

  assign wm_cond = samples_cfg == '0
                   || ((mode == accel_fifo_pkg::MODE_FIFO || mode == accel_fifo_pkg::MODE_STREAM)
                   && count_r >= CW'(samples_cfg));
  assign rd_src  = reg_req_i.rd && reg_req_i.addr == accel_fifo_pkg::OFS_EVENT_SOURCE;
  assign source  = {out_valid_r, single_r, double_r, 3'b000, wm_r, ovr_r};
  assign events  = source & event_enable_r;
  assign line_one = |(events & ~event_map_r);
  assign line_two = |(events & event_map_r);

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wm_r  <= 1'b0;
      ovr_r <= 1'b0;
    end
    else
    begin
      wm_r  <= wm_cond || (wm_r && !pop_out);
      ovr_r <= lost || (ovr_r && !pop_out);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      single_r <= 1'b0;
      double_r <= 1'b0;
    end
    else
    begin
      single_r <= single_ev || (single_r && !rd_src);
      double_r <= double_ev || (double_r && !rd_src);
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      trig_r <= 1'b0;
    end
    else if (wr_ctl)
    begin
      trig_r <= 1'b0;
    end
    else if (mode == accel_fifo_pkg::MODE_TRIGGER
             && (sample_buffer_control_r[accel_fifo_pkg::CTL_TRIG_SRC] ? line_two : line_one))
    begin
      trig_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      interrupt_output_one_o <= 1'b0;
      interrupt_output_two_o <= 1'b0;
    end
    else
    begin
      interrupt_output_one_o <= line_one ^ output_format_control_r[accel_fifo_pkg::FMT_INVERT];
      interrupt_output_two_o <= line_two ^ output_format_control_r[accel_fifo_pkg::FMT_INVERT];
    end
  end

  // ----------------------------------------
  // Tap detection
  // ----------------------------------------
  accel_fifo_pkg::tap_state_t tap_r;
  logic [7:0] tap_cnt_r;
  logic [2:0] tap_axes_r, hits;
  logic       any_hit, dbl_on, resolve;
  logic       suppress, lat_end, win_end, too_long;

  assign hits    = {above_thr(sample_i.x, tap_threshold_r), above_thr(sample_i.y, tap_threshold_r),
                    above_thr(sample_i.z, tap_threshold_r)} & tap_axis_select_r[2:0];
  assign any_hit = |hits;
  assign dbl_on  = event_enable_r[accel_fifo_pkg::EV_DOUBLE_TAP]
                   && tap_latency_time_r != '0 && second_tap_window_r != '0;
  assign suppress = tap_axis_select_r[accel_fifo_pkg::AXIS_SUPPRESS];
  assign lat_end  = tap_cnt_r == tap_latency_time_r;
  assign win_end  = tap_cnt_r == second_tap_window_r;
  assign too_long = tap_cnt_r >= tap_max_duration_r;

  always_comb
  begin
    resolve   = 1'b0;
    double_ev = 1'b0;
    if (accept)
    begin
      unique case (tap_r)
        accel_fifo_pkg::TAP_IDLE:    resolve = 1'b0;
        accel_fifo_pkg::TAP_FIRST:   resolve = !any_hit && !dbl_on;
        accel_fifo_pkg::TAP_LATENCY: resolve = any_hit && (suppress || lat_end);
        accel_fifo_pkg::TAP_WINDOW:  resolve = !any_hit && win_end;
        accel_fifo_pkg::TAP_SECOND:  resolve = !any_hit || too_long;
        default:                     resolve = 1'b0;
      endcase
      double_ev = dbl_on && tap_r == accel_fifo_pkg::TAP_SECOND && !any_hit
                  && tap_cnt_r <= tap_max_duration_r;
    end
    single_ev = resolve && event_enable_r[accel_fifo_pkg::EV_SINGLE_TAP];
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tap_r     <= accel_fifo_pkg::TAP_IDLE;
      tap_cnt_r <= '0;
    end
    else if (accept)
    begin
      tap_cnt_r <= 8'(tap_cnt_r + 1'b1);
      unique case (tap_r)
        accel_fifo_pkg::TAP_IDLE:
        begin
          tap_cnt_r <= '0;
          if (any_hit)
          begin
            tap_r <= accel_fifo_pkg::TAP_FIRST;
          end
        end
        accel_fifo_pkg::TAP_FIRST:
        begin
          if (any_hit && tap_cnt_r >= tap_max_duration_r)
          begin
            tap_r <= accel_fifo_pkg::TAP_IDLE;
          end
          else if (!any_hit)
          begin
            tap_cnt_r <= '0;
            tap_r     <= dbl_on ? accel_fifo_pkg::TAP_LATENCY : accel_fifo_pkg::TAP_IDLE;
          end
        end
        accel_fifo_pkg::TAP_LATENCY:
        begin
          if (resolve)
          begin
            tap_r <= accel_fifo_pkg::TAP_IDLE;
          end
          else if (tap_cnt_r == tap_latency_time_r)
          begin
            tap_cnt_r <= '0;
            tap_r     <= accel_fifo_pkg::TAP_WINDOW;
          end
        end
        accel_fifo_pkg::TAP_WINDOW:
        begin
          if (any_hit)
          begin
            tap_cnt_r <= '0;
            tap_r     <= accel_fifo_pkg::TAP_SECOND;
          end
          else if (resolve)
          begin
            tap_r <= accel_fifo_pkg::TAP_IDLE;
          end
        end
        accel_fifo_pkg::TAP_SECOND:
        begin
          if (resolve)
          begin
            tap_r <= accel_fifo_pkg::TAP_IDLE;
          end
        end
        default: tap_r <= accel_fifo_pkg::TAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tap_axes_r                 <= '0;
      motion_event_axis_status_r <= accel_fifo_pkg::REG_RESET;
    end
    else
    begin
      if (accept && tap_r == accel_fifo_pkg::TAP_IDLE && any_hit)
      begin
        tap_axes_r <= hits;
      end
      if (single_ev || double_ev)
      begin
        motion_event_axis_status_r <= {5'b00000, tap_axes_r};
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= '0;
    end
    else if (reg_req_i.rd)
    begin
      unique case (reg_req_i.addr)
        accel_fifo_pkg::OFS_TAP_THRESHOLD:     reg_rdata_o <= tap_threshold_r;
        accel_fifo_pkg::OFS_TAP_MAX_DURATION:  reg_rdata_o <= tap_max_duration_r;
        accel_fifo_pkg::OFS_TAP_LATENCY_TIME:  reg_rdata_o <= tap_latency_time_r;
        accel_fifo_pkg::OFS_SECOND_TAP_WINDOW: reg_rdata_o <= second_tap_window_r;
        accel_fifo_pkg::OFS_TAP_AXIS_SELECT:   reg_rdata_o <= tap_axis_select_r;
        accel_fifo_pkg::OFS_MOTION_AXIS_STAT:  reg_rdata_o <= motion_event_axis_status_r;
        accel_fifo_pkg::OFS_EVENT_ENABLE:      reg_rdata_o <= event_enable_r;
        accel_fifo_pkg::OFS_EVENT_MAP:         reg_rdata_o <= event_map_r;
        accel_fifo_pkg::OFS_EVENT_SOURCE:      reg_rdata_o <= source;
        accel_fifo_pkg::OFS_OUTPUT_FORMAT:     reg_rdata_o <= output_format_control_r;
        accel_fifo_pkg::OFS_X_AXIS_LOW_BYTE:   reg_rdata_o <= out_r.x[7:0];
        accel_fifo_pkg::OFS_X_AXIS_HIGH_BYTE:  reg_rdata_o <= out_r.x[15:8];
        accel_fifo_pkg::OFS_Y_AXIS_LOW_BYTE:   reg_rdata_o <= out_r.y[7:0];
        accel_fifo_pkg::OFS_Y_AXIS_HIGH_BYTE:  reg_rdata_o <= out_r.y[15:8];
        accel_fifo_pkg::OFS_Z_AXIS_LOW_BYTE:   reg_rdata_o <= out_r.z[7:0];
        accel_fifo_pkg::OFS_Z_AXIS_HIGH_BYTE:  reg_rdata_o <= out_r.z[15:8];
        accel_fifo_pkg::OFS_BUFFER_CONTROL:    reg_rdata_o <= sample_buffer_control_r;
        accel_fifo_pkg::OFS_BUFFER_STATUS:     reg_rdata_o <= {trig_r, 7'(count_r)};
        default:                               reg_rdata_o <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_fifo_no_grow:    assert property (mode == accel_fifo_pkg::MODE_FIFO && full
                       && !move && !wr_ctl |=> count_r == CW'(DEPTH))
                       else $error("fifo mode grew past depth");
  a_count_bound:     assert property (count_r <= CW'(DEPTH))
                       else $error("stored count above depth");
  a_stream_keep:     assert property (mode == accel_fifo_pkg::MODE_STREAM && full
                       && accept && !move && !wr_ctl |=> full && ovr_r)
                       else $error("stream full did not keep depth");
  a_zero_watermark:  assert property (samples_cfg == '0 |=> wm_r)
                       else $error("zero sample count did not set watermark");
  a_pop_clears:      assert property (pop_out && !move
                       && !(mode == accel_fifo_pkg::MODE_BYPASS && accept) |=> !out_valid_r)
                       else $error("burst end did not pop output");
  a_sleep_hold:      assert property (sleep_i && !wr_ctl
                       |=> count_r <= $past(count_r)) else $error("buffer grew during sleep");
  a_trig_status:     assert property (reg_req_i.rd
                       && reg_req_i.addr == accel_fifo_pkg::OFS_BUFFER_STATUS
                       |=> reg_rdata_o[accel_fifo_pkg::STAT_TRIG] == $past(trig_r))
                       else $error("trigger bit wrong");
  a_double_gate:     assert property (!dbl_on |-> !double_ev)
                       else $error("double tap without latency and window");
  a_status_sticky:   assert property (rd_src && !single_ev && !double_ev
                       |=> $stable(motion_event_axis_status_r)) else $error("tap status cleared on read");
  a_line_route:      assert property (events[accel_fifo_pkg::EV_OVERRUN]
                       && !event_map_r[accel_fifo_pkg::EV_OVERRUN]
                       |=> interrupt_output_one_o
                       != $past(output_format_control_r[accel_fifo_pkg::FMT_INVERT]))
                       else $error("overrun not routed to line one");

  c_fifo_full:       cover property (mode == accel_fifo_pkg::MODE_FIFO && full);
  c_trigger_hit:     cover property (!trig_r ##1 trig_r);
  c_double_tap:      cover property (double_ev);
  c_bypass_overrun:  cover property (mode == accel_fifo_pkg::MODE_BYPASS && lost);

endmodule

// [verification/accel_host_model.sv]
// Host model driving the serial register port
module accel_host_model
(
  // Clock
  input  wire logic                mclk_i,
  // Register port
  input  wire logic [7:0]          reg_rdata_i,
  output accel_fifo_pkg::reg_req_t reg_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial reg_req_o = '0;
  // One byte access, held up to the taking edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic e, output logic [7:0] q);
    @(posedge mclk_i);
    reg_req_o <= '{rd: !w, wr: w, burst_end: e, addr: a, wdata: d};
    @(posedge mclk_i);
    reg_req_o <= '0;
    #1 q = reg_rdata_i;
  endtask
  // Whole sample in one transaction
  task automatic burst(output logic [7:0] b [6]);
    for (int k = 0; k < 6; k++)
      acc(1'b0, 8'h32 + 8'(k), 8'h00, k == 5, b[k]);
  endtask
endmodule

// [verification/accel_output_fifo_tap_detect_tb_top.sv]
// Self-checking bench of the output bytes, sample buffer and tap logic
module accel_output_fifo_tap_detect_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk_i;
  logic                     resetn_i;
  logic                     sample_valid_i;
  logic                     sleep_i;
  logic                     irq1;
  logic                     irq2;
  logic [7:0]               rdata;
  logic [7:0]               q;
  logic [7:0]               b [6];
  accel_fifo_pkg::sample_t  sample_i;
  accel_fifo_pkg::sample_t  s;
  accel_fifo_pkg::reg_req_t req;
  int                       bad_count = 0;
  int                       compares = 0;
  accel_output_fifo_tap_detect dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .sample_valid_i(sample_valid_i), .sample_i(sample_i), .sleep_i(sleep_i),
    .reg_req_i(req), .reg_rdata_o(rdata),
    .interrupt_output_one_o(irq1), .interrupt_output_two_o(irq2));
  accel_host_model host (.mclk_i(mclk_i), .reg_rdata_i(rdata), .reg_req_o(req));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, 1'b0, q);
    chk(q & m, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, 1'b0, q);
  endtask
  task automatic put(input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    @(posedge mclk_i);
    sample_valid_i <= 1'b1;
    sample_i <= '{x: x, y: y, z: z};
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
  endtask
  task automatic t_bypass;
    s = '{x: 16'h8001, y: 16'h7FFE, z: 16'h00C3};
    @(posedge mclk_i);
    sleep_i <= 1'b1;
    put(16'h0005, 16'h0006, 16'h0007);
    @(posedge mclk_i);
    sleep_i <= 1'b0;
    rdm(8'h30, 8'h80, 8'h00);
    put(16'hFFFE, 16'h1234, 16'hFF00);
    put(s.x, s.y, s.z);
    rdm(8'h30, 8'h81, 8'h81);
    host.burst(b);
    for (int k = 0; k < 6; k++)
      chk(b[k], 8'({s.z, s.y, s.x} >> (8 * k)));
    rdm(8'h30, 8'h81, 8'h00);
  endtask
  task automatic t_fifo;
    wr(8'h38, 8'h44);
    host.acc(1'b0, 8'h32, 8'h00, 1'b1, q);
    rdm(8'h30, 8'h02, 8'h00);
    wr(8'h38, 8'h40);
    rdm(8'h30, 8'h02, 8'h02);
    wr(8'h38, 8'h44);
    for (int i = 1; i <= 34; i++)
      put(16'(i), 16'h0000, 16'h0000);
    rdm(8'h39, 8'hFF, 8'h20);
    rdm(8'h30, 8'h03, 8'h03);
    host.burst(b);
    chk(b[0], 8'h01);
    rdm(8'h39, 8'hFF, 8'h1F);
  endtask
  task automatic t_stream;
    wr(8'h38, 8'h84);
    for (int i = 0; i < 40; i++)
      put(16'(i), 16'h0000, 16'h0000);
    rdm(8'h39, 8'h3F, 8'h20);
    rdm(8'h30, 8'h01, 8'h01);
    wr(8'h2E, 8'h01);
    @(posedge mclk_i);
    #1 chk({6'h00, irq2, irq1}, 8'h01);
  endtask
  task automatic t_tap;
    wr(8'h1D, 8'h01);
    wr(8'h21, 8'h05);
    wr(8'h2A, 8'h04);
    wr(8'h2E, 8'h40);
    wr(8'h38, 8'hC2);
    put(16'd100, 16'h0000, 16'h0000);
    put(16'h0000, 16'h0000, 16'h0000);
    rdm(8'h39, 8'h80, 8'h80);
    chk({6'h00, irq2, irq1}, 8'h01);
    rdm(8'h2B, 8'h07, 8'h04);
    rdm(8'h30, 8'h40, 8'h40);
    @(posedge mclk_i);
    #1 chk({6'h00, irq2, irq1}, 8'h00);
    rdm(8'h2B, 8'h07, 8'h04);
  endtask
  task automatic t_double;
    wr(8'h22, 8'h02);
    wr(8'h23, 8'h03);
    wr(8'h2F, 8'h20);
    wr(8'h2E, 8'h60);
    put(16'd100, 16'h0000, 16'h0000);
    repeat (4) put(16'h0000, 16'h0000, 16'h0000);
    rdm(8'h30, 8'h60, 8'h00);
    put(16'd100, 16'h0000, 16'h0000);
    put(16'h0000, 16'h0000, 16'h0000);
    rdm(8'h30, 8'h60, 8'h60);
    chk({6'h00, irq2, irq1}, 8'h03);
    wr(8'h2A, 8'h0C);
    put(16'd100, 16'h0000, 16'h0000);
    put(16'h0000, 16'h0000, 16'h0000);
    put(16'd100, 16'h0000, 16'h0000);
    rdm(8'h30, 8'h60, 8'h40);
    wr(8'h2A, 8'h04);
    put(16'd100, 16'h0000, 16'h0000);
    repeat (3) put(16'h0000, 16'h0000, 16'h0000);
    put(16'd100, 16'h0000, 16'h0000);
    rdm(8'h30, 8'h60, 8'h40);
  endtask
  task automatic stop_test;
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100us;
    bad_count++;
    stop_test();
  end
  initial
  begin
    resetn_i = 1'b0;
    sample_valid_i = 1'b0;
    sleep_i = 1'b0;
    sample_i = '0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    t_bypass();
    t_fifo();
    t_stream();
    t_tap();
    t_double();
    stop_test();
  end
endmodule
